// file: rtu_params.svh
// Constants for the RTU link master: codes, addresses, CRC, frame sizes and timing figures
`ifndef RTU_PARAMS_SVH
`define RTU_PARAMS_SVH

`define RTU_CRC_INIT    16'hffff
`define RTU_CRC_POLY    16'ha001
`define RTU_CRC_GOOD    16'h0000
`define RTU_ADDR_BCAST  8'h00
`define RTU_ADDR_MAX    8'hf7
`define RTU_CMD_READ    8'h03
`define RTU_CMD_WRITE   8'h06
`define RTU_EXC_BIT     7
`define RTU_CRC_LSB     7:0
`define RTU_CRC_MSB     15:8
`define RTU_TX_BYTES    6
`define RTU_MIN_FRAME   4
`define RTU_CLK_HZ      250000000
`define RTU_BAUD_DEF    9600
`define RTU_CHAR_BITS   11
`define RTU_RX_MAX      40
`define RTU_GAP15_X10   15
`define RTU_GAP35_X10   35
`define RTU_X10         10

`endif

// file: rtu_pkg.sv
// Types shared by the RTU link master
package rtu_pkg;

  typedef enum logic [1:0] {
    RTU_PAR_NONE,
    RTU_PAR_EVEN,
    RTU_PAR_ODD
  } rtu_par_e;

  // One character: eight data bits and the check bit
  typedef struct packed {
    logic [7:0] data;
    logic       chk;
  } rtu_char_s;

  // Request: address, command code and two data words
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  code;
    logic [15:0] word0;
    logic [15:0] word1;
  } rtu_cmd_s;

  // Summary of one received frame
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] code;
    logic [7:0] len;
    logic       crc_ok;
    logic       par_err;
    logic       exc;
  } rtu_rsp_s;

endpackage

// file: rtu_master.sv
// RTU link master: frame sender, response framer, parity and CRC checker
`timescale 1ns/1ps
`include "rtu_params.svh"

module rtu_master #(
  parameter int unsigned CLK_HZ    = `RTU_CLK_HZ,
  parameter int unsigned BAUD      = `RTU_BAUD_DEF,
  parameter int unsigned CHAR_BITS = `RTU_CHAR_BITS,
  parameter int unsigned CHAR_CYC  = 32'((64'(CLK_HZ) * 64'(CHAR_BITS)) / 64'(BAUD)),
  parameter int unsigned RX_MAX    = `RTU_RX_MAX,
  parameter int unsigned IW        = $clog2(RX_MAX)
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire rtu_pkg::rtu_par_e  parity_i,
  input  wire logic               cmd_valid_i,
  input  wire rtu_pkg::rtu_cmd_s  cmd_i,
  output logic                    cmd_ready_o,
  output logic                    cmd_rej_o,
  output logic                    txc_valid_o,
  output rtu_pkg::rtu_char_s      txc_o,
  input  wire logic               txc_ready_i,
  input  wire logic               rxc_valid_i,
  input  wire rtu_pkg::rtu_char_s rxc_i,
  output logic                    rsp_valid_o,
  output rtu_pkg::rtu_rsp_s       rsp_o,
  output logic                    drop_o,
  input  wire logic [IW-1:0]      rd_idx_i,
  output logic [7:0]              rd_byte_o
);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // thresholds from baud
  localparam int unsigned T15_CYC = (CHAR_CYC * `RTU_GAP15_X10) / `RTU_X10;
  localparam int unsigned T35_CYC = (CHAR_CYC * `RTU_GAP35_X10) / `RTU_X10;
  // Counter restarts at hand-off of a character, one character before it leaves the wire
  localparam int unsigned TXGAP_CYC = T35_CYC + CHAR_CYC;

  // Length count is eight bits and the read index must reach every buffer slot
  if (CHAR_CYC < 2 || RX_MAX < `RTU_MIN_FRAME || RX_MAX > 255 || IW < $clog2(RX_MAX)) begin : g_bad_cfg
    $error("rtu_master: unsupported baud or buffer size");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // bitwise CRC step
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RTU_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic par_bit(input rtu_pkg::rtu_par_e m, input logic [7:0] d);
    logic p;
    case (m)
      rtu_pkg::RTU_PAR_EVEN: p = ^d;
      rtu_pkg::RTU_PAR_ODD:  p = ~^d;
      default:               p = 1'b0;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_GAP, TX_BYTE, TX_CRCL, TX_CRCH} rtu_tx_e;
  rtu_tx_e                  tx_st_r,    tx_st_nxt;
  logic [47:0]              frm_r,      frm_nxt;
  logic [2:0]               idx_r,      idx_nxt;
  logic [15:0]              crc_r,      crc_nxt;
  logic                     rdy_r,      rdy_nxt;
  logic                     rej_r,      rej_nxt;
  logic                     tv_r,       tv_nxt;
  rtu_pkg::rtu_char_s       tc_r,       tc_nxt;
  logic [31:0]              idle_r,     idle_nxt;
  logic                     tx_take;
  logic [7:0]               byte_sel;
  assign tx_take  = tv_r && txc_ready_i;
  assign byte_sel = frm_r[47:40];
  always_comb begin
    tx_st_nxt = tx_st_r;
    frm_nxt   = frm_r;
    idx_nxt   = idx_r;
    crc_nxt   = crc_r;
    rdy_nxt   = rdy_r;
    rej_nxt   = 1'b0;
    tv_nxt    = tv_r;
    tc_nxt    = tc_r;
    case (tx_st_r)
      TX_IDLE: begin
        if (cmd_valid_i && rdy_r) begin
          if (cmd_i.addr > `RTU_ADDR_MAX) begin
            rej_nxt = 1'b1;
          end else begin
            // address, code, then words high byte first
            frm_nxt   = {cmd_i.addr, cmd_i.code, cmd_i.word0, cmd_i.word1};
            crc_nxt   = `RTU_CRC_INIT;
            idx_nxt   = 3'h0;
            rdy_nxt   = 1'b0;
            tx_st_nxt = TX_GAP;
          end
        end
      end
      TX_GAP: begin
        if (idle_r >= TXGAP_CYC) begin
          tv_nxt    = 1'b1;
          tc_nxt    = '{data: byte_sel, chk: par_bit(parity_i, byte_sel)};
          tx_st_nxt = TX_BYTE;
        end
      end
      TX_BYTE: begin
        if (tx_take) begin
          crc_nxt = crc_byte(crc_r, tc_r.data);
          frm_nxt = {frm_r[39:0], 8'h00};
          if (idx_r == 3'(`RTU_TX_BYTES - 1)) begin
            tc_nxt    = '{data: crc_nxt[`RTU_CRC_LSB], chk: par_bit(parity_i, crc_nxt[`RTU_CRC_LSB])};
            tx_st_nxt = TX_CRCL;
          end else begin
            idx_nxt = idx_r + 3'h1;
            tc_nxt  = '{data: frm_r[39:32], chk: par_bit(parity_i, frm_r[39:32])};
          end
        end
      end
      TX_CRCL: begin
        if (tx_take) begin
          tc_nxt    = '{data: crc_r[`RTU_CRC_MSB], chk: par_bit(parity_i, crc_r[`RTU_CRC_MSB])};
          tx_st_nxt = TX_CRCH;
        end
      end
      TX_CRCH: begin
        if (tx_take) begin
          tv_nxt    = 1'b0;
          rdy_nxt   = 1'b1;
          tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      frm_r   <= '0;
      idx_r   <= 3'h0;
      crc_r   <= `RTU_CRC_INIT;
      rdy_r   <= 1'b1;
      rej_r   <= 1'b0;
      tv_r    <= 1'b0;
      tc_r    <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      frm_r   <= frm_nxt;
      idx_r   <= idx_nxt;
      crc_r   <= crc_nxt;
      rdy_r   <= rdy_nxt;
      rej_r   <= rej_nxt;
      tv_r    <= tv_nxt;
      tc_r    <= tc_nxt;
    end
  end

  assign cmd_ready_o = rdy_r;
  assign cmd_rej_o   = rej_r;
  assign txc_valid_o = tv_r;
  assign txc_o       = tc_r;

  // ----------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------
  logic [7:0]               len_r,      len_nxt;
  logic [15:0]              rcrc_r,     rcrc_nxt;
  logic                     perr_r,     perr_nxt;
  logic [7:0]               raddr_r,    raddr_nxt;
  logic [7:0]               rcode_r,    rcode_nxt;
  logic                     rv_r,       rv_nxt;
  rtu_pkg::rtu_rsp_s        rsp_r,      rsp_nxt;
  logic                     drop_r,     drop_nxt;
  logic                     bad;
  logic [7:0]               rx_buf [RX_MAX];
  logic [7:0]               rd_r;
  assign bad = (parity_i != rtu_pkg::RTU_PAR_NONE) && (rxc_i.chk != par_bit(parity_i, rxc_i.data));
  always_comb begin
    len_nxt   = len_r;
    rcrc_nxt  = rcrc_r;
    perr_nxt  = perr_r;
    raddr_nxt = raddr_r;
    rcode_nxt = rcode_r;
    rv_nxt    = 1'b0;
    rsp_nxt   = rsp_r;
    drop_nxt  = 1'b0;
    idle_nxt  = (idle_r == 32'hffffffff) ? idle_r : idle_r + 32'h1;
    if (rxc_valid_i || tx_take) begin
      idle_nxt = 32'h0;
    end
    if (rxc_valid_i) begin
      if (len_r == 8'h00 || idle_r > T15_CYC) begin
        // late byte opens a new frame
        drop_nxt  = (len_r != 8'h00);
        raddr_nxt = rxc_i.data;
        len_nxt   = 8'h01;
        rcrc_nxt  = crc_byte(`RTU_CRC_INIT, rxc_i.data);
        perr_nxt  = bad;
      end else begin
        if (len_r == 8'h01) begin
          rcode_nxt = rxc_i.data;
        end
        len_nxt  = (len_r == 8'(RX_MAX)) ? len_r : len_r + 8'h01;
        rcrc_nxt = crc_byte(rcrc_r, rxc_i.data);
        perr_nxt = perr_r | bad;
      end
    end else if (len_r != 8'h00 && idle_r == T35_CYC) begin
      rv_nxt  = 1'b1;
      len_nxt = 8'h00;
      // residue over data and CRC is zero
      rsp_nxt.crc_ok  = (rcrc_r == `RTU_CRC_GOOD) && (len_r >= 8'(`RTU_MIN_FRAME));
      rsp_nxt.addr    = raddr_r;
      rsp_nxt.code    = rcode_r;
      rsp_nxt.len     = len_r;
      rsp_nxt.par_err = perr_r;
      // reply code echoes the request; top bit marks an error frame
      rsp_nxt.exc     = rcode_r[`RTU_EXC_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      len_r   <= 8'h00;
      rcrc_r  <= `RTU_CRC_INIT;
      perr_r  <= 1'b0;
      raddr_r <= 8'h00;
      rcode_r <= 8'h00;
      rv_r    <= 1'b0;
      rsp_r   <= '0;
      drop_r  <= 1'b0;
      idle_r  <= 32'hffffffff;
    end else begin
      len_r   <= len_nxt;
      rcrc_r  <= rcrc_nxt;
      perr_r  <= perr_nxt;
      raddr_r <= raddr_nxt;
      rcode_r <= rcode_nxt;
      rv_r    <= rv_nxt;
      rsp_r   <= rsp_nxt;
      drop_r  <= drop_nxt;
      idle_r  <= idle_nxt;
    end
  end

  // Frame bytes kept for the user; slot 0 rewritten when a new frame opens
  always_ff @(posedge clk_i) begin
    if (rxc_valid_i && len_nxt != 8'h00 && len_nxt <= 8'(RX_MAX) && !(len_r == 8'(RX_MAX) && len_nxt == len_r)) begin
      rx_buf[IW'(len_nxt - 8'h01)] <= rxc_i.data;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= (32'(rd_idx_i) < RX_MAX) ? rx_buf[rd_idx_i] : 8'h00;
    end
  end

  assign rsp_valid_o = rv_r;
  assign rsp_o       = rsp_r;
  assign drop_o      = drop_r;
  assign rd_byte_o   = rd_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_crc_preset: assert property (tx_st_r == TX_IDLE && tx_st_nxt == TX_GAP |=> crc_r == `RTU_CRC_INIT)
    else $error("CRC not preset at frame start");
  a_tx_idle_gap: assert property (tx_st_r == TX_BYTE && idx_r == 3'h0 |-> idle_r >= TXGAP_CYC)
    else $error("Frame started without idle gap");
  a_addr_first: assert property ($rose(tv_r) |-> tc_r.data <= `RTU_ADDR_MAX)
    else $error("Address byte out of range");
  a_crc_low: assert property (tx_st_r == TX_BYTE && tx_take && idx_r == 3'(`RTU_TX_BYTES - 1)
                               |=> tc_r.data == crc_r[`RTU_CRC_LSB])
    else $error("CRC low byte not sent first");
  a_crc_high: assert property (tx_st_r == TX_CRCL && tx_take |=> tc_r.data == $past(crc_r[`RTU_CRC_MSB]))
    else $error("CRC high byte wrong");
  a_par_even: assert property (tv_r && parity_i == rtu_pkg::RTU_PAR_EVEN && $stable(parity_i)
                               |-> tc_r.chk == ^tc_r.data)
    else $error("Even check bit wrong");
  a_par_odd: assert property (tv_r && parity_i == rtu_pkg::RTU_PAR_ODD && $stable(parity_i)
                              |-> tc_r.chk != ^tc_r.data)
    else $error("Odd check bit wrong");
  a_par_rx: assert property (rxc_valid_i && bad |=> perr_r)
    else $error("Parity error not recorded");
  a_gap_drop: assert property (rxc_valid_i && len_r != 8'h00 && idle_r > T15_CYC
                               |=> drop_o && len_r == 8'h01)
    else $error("Late byte did not restart frame");
  a_frame_end: assert property (rsp_valid_o |-> $past(idle_r) == T35_CYC && len_r == 8'h00)
    else $error("Frame closed at wrong time");
  a_words_hi: assert property ($fell(rdy_r) |-> frm_r[31:16] == $past(cmd_i.word0))
    else $error("Word byte order wrong");

endmodule // rtu_master

// file: rtu_slave_model.sv
// Behavioural slave station on the far side of the RTU link master
`timescale 1ns/1ps
module rtu_slave_model #(
  parameter int unsigned CHAR_CYC = 20
) (
  input  wire logic               clk_i,
  input  wire rtu_pkg::rtu_par_e  parity_i,
  input  wire logic [7:0]         own_addr_i,
  input  wire logic [2:0]         mode_i,
  input  wire logic               slow_i,
  input  wire logic               txc_valid_i,
  input  wire rtu_pkg::rtu_char_s txc_i,
  output logic                    txc_ready_o,
  output logic                    rxc_valid_o,
  output rtu_pkg::rtu_char_s      rxc_o
);
  logic [7:0] q[$];
  logic       pe    = 1'b0;
  logic       tog_r = 1'b0;

  // Slow mode takes a character only every other cycle
  assign txc_ready_o = !slow_i || tog_r;
  always @(posedge clk_i) tog_r <= !tog_r;

  function automatic logic par(input logic [7:0] d);
    return parity_i == rtu_pkg::RTU_PAR_NONE ? 1'b0 : parity_i == rtu_pkg::RTU_PAR_EVEN ? ^d : ~^d;
  endfunction

  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic reply();
    logic [7:0]  r[$];
    logic [15:0] c;
    if (q[0] == 8'h00 || q[0] != own_addr_i) return;
    if (pe || crc(q) != 16'h0000 || mode_i == 3'h3) r = {q[0], q[1] | 8'h80, 8'h01};
    else r = q[0:5];
    c = crc(r);
    r.push_back(c[7:0]);
    r.push_back(c[15:8] ^ {7'h00, mode_i == 3'h2});
    repeat (4 * CHAR_CYC) @(posedge clk_i);
    foreach (r[i]) begin
      if (mode_i == 3'h4 && i == 3) repeat (2 * CHAR_CYC) @(posedge clk_i);
      rxc_valid_o <= 1'b1;
      rxc_o       <= '{r[i], par(r[i]) ^ (mode_i == 3'h1 && i == 2)};
      @(posedge clk_i);
      rxc_valid_o <= 1'b0;
      rxc_o       <= '{~r[i], 1'b1};
      repeat (CHAR_CYC - 1) @(posedge clk_i);
    end
  endtask

  initial begin
    rxc_valid_o = 1'b0;
    rxc_o       = '0;
    forever begin
      @(posedge clk_i);
      if (txc_valid_i && txc_ready_o) begin
        pe |= txc_i.chk != par(txc_i.data);
        q.push_back(txc_i.data);
        if (q.size() == 8) begin
          reply();
          q.delete();
          pe = 1'b0;
        end
      end
    end
  end
endmodule // rtu_slave_model

// file: rtu_master_tb.sv
// Self-checking bench: RTU link master against a slave station model
`timescale 1ns/1ps
module rtu_master_tb;
  localparam int unsigned CC = 20;
  logic               clk_i       = 1'b0;
  logic               rst_i       = 1'b1;
  rtu_pkg::rtu_par_e  parity_i    = rtu_pkg::RTU_PAR_EVEN;
  logic               cmd_valid_i = 1'b0;
  rtu_pkg::rtu_cmd_s  cmd_i       = '0;
  logic [5:0]         rd_idx_i    = 6'h07;
  logic [7:0]         own         = 8'h02;
  logic [2:0]         mode        = 3'h0;
  logic               slow        = 1'b0;
  logic               cmd_ready_o, cmd_rej_o, txc_valid_o, txc_ready_i, rxc_valid_i, rsp_valid_o, drop_o;
  logic [7:0]         rd_byte_o;
  rtu_pkg::rtu_char_s txc_o, rxc_i, txq[8];
  rtu_pkg::rtu_rsp_s  rsp_o, rsp_q;
  int                 txt[8];
  int                 ntx, nrsp, ndrop, nrej, num_errors, num_checks;

  always #2 clk_i = ~clk_i;

  rtu_master #(.CHAR_CYC(CC)) u_rtu_master (.clk_i(clk_i), .rst_i(rst_i), .parity_i(parity_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_rej_o(cmd_rej_o),
    .txc_valid_o(txc_valid_o), .txc_o(txc_o), .txc_ready_i(txc_ready_i), .rxc_valid_i(rxc_valid_i),
    .rxc_i(rxc_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .drop_o(drop_o), .rd_idx_i(rd_idx_i),
    .rd_byte_o(rd_byte_o));
  rtu_slave_model #(.CHAR_CYC(CC)) u_rtu_slave_model (.clk_i(clk_i), .parity_i(parity_i),
    .own_addr_i(own), .mode_i(mode), .slow_i(slow), .txc_valid_i(txc_valid_o), .txc_i(txc_o),
    .txc_ready_o(txc_ready_i), .rxc_valid_o(rxc_valid_i), .rxc_o(rxc_i));

  always @(posedge clk_i) begin
    if (txc_valid_o && txc_ready_i && ntx < 8) begin
      txq[ntx] = txc_o;
      txt[ntx] = int'($time / 4);
    end
    ntx += int'(txc_valid_o && txc_ready_i);
    if (rsp_valid_o) rsp_q = rsp_o;
    nrsp  += int'(rsp_valid_o);
    ndrop += int'(drop_o);
    nrej  += int'(cmd_rej_o);
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cnt(ref int c, input int v);
    for (int n = 0; n < 2000 && c < v; n++) @(posedge clk_i);
    if (c < v) begin
      chk(c, v);
      finish_test();
    end
  endtask

  function automatic logic pbit(input logic [7:0] d);
    return parity_i == rtu_pkg::RTU_PAR_NONE ? 1'b0 : parity_i == rtu_pkg::RTU_PAR_EVEN ? ^d : ~^d;
  endfunction

  function automatic logic [15:0] crc6(input logic [47:0] v);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--) begin
      c ^= {8'h00, v[8*i +: 8]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic send(input rtu_pkg::rtu_cmd_s c);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 3000);
    chk(32'(n < 3000), 32'h1);
    if (n >= 3000) finish_test();
    cmd_valid_i <= 1'b1;
    cmd_i       <= c;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask

  // Sends one request and checks every character put on the line
  task automatic run(input rtu_pkg::rtu_cmd_s c, input bit want);
    logic [63:0] e;
    logic [15:0] k;
    int          r0;
    k   = crc6(c);
    e   = {c, k[7:0], k[15:8]};
    r0  = nrsp;
    ntx = 0;
    send(c);
    wait_cnt(ntx, 8);
    for (int i = 0; i < 8; i++)
      chk(txq[i], {e[63-8*i -: 8], pbit(e[63-8*i -: 8])});
    if (want) wait_cnt(nrsp, r0 + 1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_write_even();
    run('{8'h02, 8'h06, 16'h0004, 16'h1388}, 1'b1);
    chk({txq[6].data, txq[7].data}, 16'hc56e);
    chk(rsp_q, {8'h02, 8'h06, 8'h08, 3'b100});
    repeat (2) @(posedge clk_i);
    chk(rd_byte_o, 8'h6e);
  endtask

  task automatic s_read_odd();
    parity_i <= rtu_pkg::RTU_PAR_ODD;
    own      <= 8'h01;
    slow     <= 1'b1;
    run('{8'h01, 8'h03, 16'h0004, 16'h0002}, 1'b1);
    chk({txq[6].data, txq[7].data}, 16'h85ca);
    chk(rsp_q, {8'h01, 8'h03, 8'h08, 3'b100});
    slow     <= 1'b0;
    own      <= 8'h02;
    parity_i <= rtu_pkg::RTU_PAR_EVEN;
  endtask

  // Bad check bit, bad CRC, then an error frame from the slave
  task automatic s_faults();
    logic [26:0] e[3];
    e = '{{8'h02, 8'h06, 8'h08, 3'b110}, {8'h02, 8'h06, 8'h08, 3'b000}, {8'h02, 8'h86, 8'h05, 3'b101}};
    for (int m = 1; m < 4; m++) begin
      mode <= 3'(m);
      run('{8'h02, 8'h06, 16'h0004, 16'h1388}, 1'b1);
      chk(rsp_q, e[m-1]);
    end
    mode <= 3'h0;
  endtask

  task automatic s_gap();
    int d0;
    d0   = ndrop;
    mode <= 3'h4;
    run('{8'h02, 8'h06, 16'h0004, 16'h1388}, 1'b1);
    chk(ndrop, d0 + 1);
    chk(rsp_q, {8'h04, 8'h13, 8'h05, 3'b000});
    rd_idx_i <= 6'h00;
    repeat (2) @(posedge clk_i);
    chk(rd_byte_o, 8'h04);
    mode <= 3'h0;
  endtask

  // Refused address, then two broadcasts back to back with no answer
  task automatic s_addr();
    int r0;
    int t0;
    r0 = nrsp;
    ntx = 0;
    parity_i <= rtu_pkg::RTU_PAR_NONE;
    send('{8'hf8, 8'h03, 16'h0000, 16'h0001});
    repeat (3) @(posedge clk_i);
    chk(nrej, 1);
    chk(ntx, 0);
    run('{8'h00, 8'h06, 16'h0004, 16'h1388}, 1'b0);
    t0 = txt[7];
    run('{8'h00, 8'h03, 16'h0004, 16'h0002}, 1'b0);
    chk(32'(txt[0] - t0 >= (7 * CC) / 2 + CC && txt[0] - t0 < (7 * CC) / 2 + CC + 6), 32'h1);
    repeat (600) @(posedge clk_i);
    chk(nrsp, r0);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    s_write_even();
    s_read_odd();
    s_faults();
    s_gap();
    s_addr();
    finish_test();
  end
endmodule // rtu_master_tb
